// file: shared/oaf_map.vh
// register offsets, field positions, reset values and codes of the operand/flag block
`ifndef OAF_MAP_VH
`define OAF_MAP_VH
`define OAF_A_PSW     8'h00
`define OAF_A_SECOND_STATUS_WORD    8'h04
`define OAF_A_ACC     8'h08
`define OAF_A_REGION  8'h0c
`define OAF_A_EDP     8'h10
`define OAF_A_BASE    8'h14
`define OAF_A_OFFS    8'h18
`define OAF_A_PC      8'h1c
`define OAF_A_CTRL    8'h20
`define OAF_A_ARES    8'h24
`define OAF_A_RDEC    8'h28
`define OAF_A_IMM     8'h2c
`define OAF_A_OPA     8'h30
`define OAF_A_OPB     8'h34
`define OAF_A_ALUCTL  8'h38
`define OAF_A_ALURES  8'h3c
`define OAF_B_CY      7
`define OAF_B_AC      6
`define OAF_B_F0      5
`define OAF_B_N       5
`define OAF_B_RS1     4
`define OAF_B_RS0     3
`define OAF_B_OV      2
`define OAF_B_UD      1
`define OAF_B_Z       1
`define OAF_B_P       0
`define OAF_RST_FLAG   1'b0
`define OAF_RST_REGION 8'h01
`define OAF_RST_WORD   32'h00000000
`define OAF_REGION_CODE 8'hff
`define OAF_REGION_LOW  8'h00
`define OAF_K_SHORT   3'h0
`define OAF_K_WIDE    3'h1
`define OAF_K_PTR     3'h2
`define OAF_K_WORD    3'h3
`define OAF_K_DWORD   3'h4
`define OAF_M_REG     4'h0
`define OAF_M_DIR8L   4'h1
`define OAF_M_INDRI   4'h2
`define OAF_M_DIR8X   4'h3
`define OAF_M_DIRECT_ADDR_16   4'h4
`define OAF_M_INDWR   4'h5
`define OAF_M_INDDR   4'h6
`define OAF_M_DISP16  4'h7
`define OAF_M_DISP24  4'h8
`define OAF_M_REL     4'h9
`define OAF_M_XDPTR   4'ha
`define OAF_M_XRI     4'hb
`define OAF_M_CDPTR   4'hc
`define OAF_M_CPC     4'hd
`define OAF_OP_ADD    4'h0
`define OAF_OP_ADD_WITH_CARRY_OP   4'h1
`define OAF_OP_SUB    4'h2
`define OAF_OP_SUBB   4'h3
`define OAF_OP_CMP    4'h4
`define OAF_OP_INC    4'h5
`define OAF_OP_DEC    4'h6
`define OAF_OP_MUL    4'h7
`define OAF_OP_DIV    4'h8
`define OAF_OP_SRL    4'h9
`define OAF_OP_SLL    4'ha
`define OAF_OP_SRA    4'hb
`endif

// file: hw/oaf_reg_decode.v
// register index decoder: index kind and bank to register-file byte locations
`timescale 1ns/10ps
`default_nettype none
`include "oaf_map.vh"
module oaf_reg_decode (
  input  wire [2:0] kind,
  input  wire [5:0] index,
  input  wire [1:0] bank,
  output reg  [7:0] msb_loc,
  output reg  [7:0] lsb_loc,
  output reg        valid,
  output wire       in_mem
);
  reg [7:0] size_m1;
  always @* begin
    valid   = 1'b0;
    size_m1 = 8'h00;
    case (kind)
      `OAF_K_SHORT: valid = (index < 6'd8);
      `OAF_K_WIDE:  valid = (index < 6'd16);
      `OAF_K_PTR:   valid = (index < 6'd2);
      `OAF_K_WORD: begin
        valid   = ~index[0] && (index <= 6'd30);
        size_m1 = 8'h01;
      end
      `OAF_K_DWORD: begin
        valid   = (index[1:0] == 2'b00) &&
                  ((index <= 6'd28) || (index == 6'd56) || (index == 6'd60));
        size_m1 = 8'h03;
      end
      default: valid = 1'b0;
    endcase
    // low indices come from the active bank, which is also memory 00h-1fh
    if (index < 6'd8)
      msb_loc = {3'b000, bank, index[2:0]};
    else
      msb_loc = {2'b00, index} + 8'h18;
    lsb_loc = msb_loc + size_m1;
  end
  assign in_mem = valid && (msb_loc < 8'h20);
endmodule
`default_nettype wire

// file: hw/oaf_flag_unit.v
// flag unit: arithmetic, multiply/divide and shift results with status flags
`timescale 1ns/10ps
`default_nettype none
`include "oaf_map.vh"
module oaf_flag_unit (
  input  wire [3:0]  op,
  input  wire [1:0]  width,
  input  wire [31:0] opa,
  input  wire [31:0] opb,
  input  wire        cy_in,
  input  wire        ac_in,
  input  wire        ov_in,
  input  wire        n_in,
  input  wire        z_in,
  output reg  [31:0] result,
  output reg         cy_out,
  output reg         ac_out,
  output reg         ov_out,
  output reg         n_out,
  output reg         z_out,
  output reg         store
);
  reg [4:0]  sh;
  reg [31:0] mask;
  reg [31:0] am;
  reg [31:0] bsel;
  reg [31:0] bm;
  reg [31:0] as_;
  reg [31:0] bs_;
  reg [31:0] prod;
  reg [31:0] quo;
  reg [31:0] rem;
  reg [32:0] sum;
  reg [4:0]  nib;
  reg        sub;
  reg        cinb;
  always @* begin
    case (width)
      2'd0:    begin sh = 5'd24; mask = 32'h000000ff; end
      2'd1:    begin sh = 5'd16; mask = 32'h0000ffff; end
      default: begin sh = 5'd0;  mask = 32'hffffffff; end
    endcase
    am   = opa & mask;
    sub  = (op == `OAF_OP_SUB) || (op == `OAF_OP_SUBB) || (op == `OAF_OP_CMP) ||
           (op == `OAF_OP_DEC);
    bsel = opb;
    if ((op == `OAF_OP_INC) || (op == `OAF_OP_DEC))
      bsel = (opb[1:0] == 2'd0) ? 32'h1 : (opb[1:0] == 2'd1) ? 32'h2 : 32'h4;
    bm   = (sub ? ~bsel : bsel) & mask;
    cinb = (op == `OAF_OP_ADD_WITH_CARRY_OP) ? cy_in : (op == `OAF_OP_SUBB) ? ~cy_in : sub;
    as_  = am << sh;
    bs_  = bm << sh;
    sum  = {1'b0, as_} + {1'b0, bs_} + ({32'h0, cinb} << sh);
    nib  = {1'b0, am[3:0]} + {1'b0, bm[3:0]} + {4'h0, cinb};
    prod = am * (opb & mask);
    quo  = ((opb & mask) == 32'h0) ? 32'h0 : am / (opb & mask);
    rem  = ((opb & mask) == 32'h0) ? 32'h0 : am % (opb & mask);
    result = opa;
    cy_out = cy_in;
    ac_out = ac_in;
    ov_out = ov_in;
    n_out  = n_in;
    z_out  = z_in;
    store  = 1'b1;
    case (op)
      `OAF_OP_ADD, `OAF_OP_ADD_WITH_CARRY_OP, `OAF_OP_SUB, `OAF_OP_SUBB, `OAF_OP_CMP: begin
        result = sum[31:0] >> sh;
        cy_out = sum[32] ^ sub;
        ov_out = (as_[31] == bs_[31]) && (sum[31] != as_[31]);
        ac_out = (width == 2'd0) ? (nib[4] ^ sub) : ac_in;
        n_out  = sum[31];
        z_out  = (sum[31:0] == 32'h0);
        store  = (op != `OAF_OP_CMP);
      end
      `OAF_OP_INC, `OAF_OP_DEC: begin
        result = sum[31:0] >> sh;
        n_out  = sum[31];
        z_out  = (sum[31:0] == 32'h0);
      end
      `OAF_OP_MUL: begin
        result = (width == 2'd0) ? {16'h0, prod[15:0]} : prod;
        cy_out = 1'b0;
        ov_out = (width == 2'd0) ? (|prod[15:8]) : (|prod[31:16]);
        n_out  = (width == 2'd0) ? prod[15] : prod[31];
        z_out  = (result == 32'h0);
      end
      `OAF_OP_DIV: begin
        result = (width == 2'd0) ? {16'h0, rem[7:0], quo[7:0]} : {rem[15:0], quo[15:0]};
        cy_out = 1'b0;
        ov_out = ((opb & mask) == 32'h0);
        n_out  = (width == 2'd0) ? quo[7] : quo[15];
        z_out  = (quo == 32'h0);
      end
      `OAF_OP_SRL, `OAF_OP_SLL, `OAF_OP_SRA: begin
        if (op == `OAF_OP_SRL) begin
          result = am >> 1;
          cy_out = am[0];
        end else if (op == `OAF_OP_SLL) begin
          result = (am << 1) & mask;
          cy_out = as_[31];
        end else begin
          result = (am >> 1) | (am & (32'h80000000 >> sh));
          cy_out = am[0];
        end
        // sign comes from the shifted value, not the operand
        n_out = |(result & (32'h80000000 >> sh));
        z_out = (result == 32'h0);
      end
      default: store = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: hw/oaf_top.v
// operand addressing and status flag block with an avalon-mm register slave
// Operation
// - short, wide and pointer byte index ranges
// - word registers even, 0 to 30
// - dword registers multiples of four, 0 to 28, 56, 60
// - first register destination, second one source
// - region above offset; register space kept apart
// - legacy upper half direct register, indirect memory
// - displacement adds instruction offset to base
// - relative target is next address plus offset
// - flags from results; parity follows accumulator
// - bank bits pick bank, banks in memory
// - status words writable except parity bit
// - shared flags are one storage
// - add, carry add, subtract, compare update flags
// - multiply and divide clear carry
// - aux carry changes on byte operations only
// - divide by zero sets overflow
// - shifts put last bit out in carry
// - legacy external region from pointer region byte
// - dword immediate upper word zeros or ones
// - word immediate to dword: upper or extended
// - increment and decrement step 1, 2, 4
// - extended direct ranges and access sizes
// - legacy code reads use region ff
// - multi-byte values most significant byte first
// - register space byte access only
`timescale 1ns/10ps
`default_nettype none
`include "oaf_map.vh"
module oaf_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg        carry_flag_reg;
  reg        aux_carry_flag_reg;
  reg        overflow_flag_reg;
  reg        bank_select_lo_reg;
  reg        bank_select_hi_reg;
  reg        user_flag_a_reg;
  reg        user_flag_b_reg;
  reg        neg_flag_reg;
  reg        zero_flag_reg;
  reg [7:0]  acc_reg;
  reg [7:0]  ext_pointer_region_byte_reg;
  reg [15:0] data_pointer_16_reg;
  reg [31:0] base_reg;
  reg [15:0] offs_reg;
  reg [23:0] next_pc_reg;
  reg [22:0] ctrl_reg;
  reg [31:0] opa_reg;
  reg [31:0] opb_reg;
  reg [5:0]  alu_ctl_reg;
  reg [31:0] alu_res_reg;
  reg        busy_reg;
  wire       busy_next;
  wire       req;
  wire       wr_take;
  wire [31:0] wmask;
  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait cycle: read data is captured at the first edge,
  // writes land at the edge where waitrequest is seen low
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~busy_reg;
  assign busy_next       = req & ~busy_reg;
  assign wr_take         = avs_write & busy_reg;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction
  wire [31:0] wd_edp  = merge({8'h00, ext_pointer_region_byte_reg, data_pointer_16_reg},
                              avs_writedata, wmask);
  wire [31:0] wd_base = merge(base_reg, avs_writedata, wmask);
  wire [31:0] wd_offs = merge({16'h0, offs_reg}, avs_writedata, wmask);
  wire [31:0] wd_pc   = merge({8'h00, next_pc_reg}, avs_writedata, wmask);
  wire [31:0] wd_ctrl = merge({9'h000, ctrl_reg}, avs_writedata, wmask);
  wire [31:0] wd_opa  = merge(opa_reg, avs_writedata, wmask);
  wire [31:0] wd_opb  = merge(opb_reg, avs_writedata, wmask);
  wire [31:0] wd_alu  = merge({26'h0, alu_ctl_reg}, avs_writedata, wmask);
  // ------------------------------------------------------------
  // status words
  // ------------------------------------------------------------
  wire       parity = ^acc_reg;
  wire [1:0] bank   = {bank_select_hi_reg, bank_select_lo_reg};
  reg  [7:0] primary_status_word;
  reg  [7:0] second_status_word;
  always @* begin
    primary_status_word              = 8'h00;
    primary_status_word[`OAF_B_CY]  = carry_flag_reg;
    primary_status_word[`OAF_B_AC]  = aux_carry_flag_reg;
    primary_status_word[`OAF_B_F0]  = user_flag_a_reg;
    primary_status_word[`OAF_B_RS1] = bank_select_hi_reg;
    primary_status_word[`OAF_B_RS0] = bank_select_lo_reg;
    primary_status_word[`OAF_B_OV]  = overflow_flag_reg;
    primary_status_word[`OAF_B_UD]  = user_flag_b_reg;
    primary_status_word[`OAF_B_P]   = parity;
    // carry, aux carry, bank and overflow flops seen through the second word; N and Z have flops of their own
    second_status_word              = 8'h00;
    second_status_word[`OAF_B_CY]   = carry_flag_reg;
    second_status_word[`OAF_B_AC]   = aux_carry_flag_reg;
    second_status_word[`OAF_B_N]    = neg_flag_reg;
    second_status_word[`OAF_B_RS1]  = bank_select_hi_reg;
    second_status_word[`OAF_B_RS0]  = bank_select_lo_reg;
    second_status_word[`OAF_B_OV]   = overflow_flag_reg;
    second_status_word[`OAF_B_Z]    = zero_flag_reg;
  end
  // ------------------------------------------------------------
  // register index decode
  // ------------------------------------------------------------
  wire [7:0] dst_msb;
  wire [7:0] dst_lsb;
  wire       dst_valid;
  wire       dst_mem;
  wire [7:0] src_msb;
  wire [7:0] src_lsb;
  wire       src_valid;
  wire       src_mem;
  // first encoded index is the destination, second the source
  oaf_reg_decode u_dst (
    .kind    (ctrl_reg[18:16]),
    .index   (ctrl_reg[9:4]),
    .bank    (bank),
    .msb_loc (dst_msb),
    .lsb_loc (dst_lsb),
    .valid   (dst_valid),
    .in_mem  (dst_mem)
  );
  oaf_reg_decode u_src (
    .kind    (ctrl_reg[18:16]),
    .index   (ctrl_reg[15:10]),
    .bank    (bank),
    .msb_loc (src_msb),
    .lsb_loc (src_lsb),
    .valid   (src_valid),
    .in_mem  (src_mem)
  );
  // ------------------------------------------------------------
  // operand address generator
  // ------------------------------------------------------------
  wire [3:0]  mode     = ctrl_reg[3:0];
  wire [1:0]  size     = ctrl_reg[20:19];
  wire [23:0] offs_sx  = {{8{offs_reg[15]}}, offs_reg};
  wire [15:0] acc_zx   = {8'h00, acc_reg};
  reg  [23:0] addr_v;
  reg         sfr_v;
  reg         err_v;
  reg         file_v;
  always @* begin
    addr_v = 24'h0;
    sfr_v  = 1'b0;
    err_v  = 1'b0;
    file_v = 1'b0;
    case (mode)
      `OAF_M_REG: begin
        addr_v = {16'h0, dst_msb};
        file_v = 1'b1;
        err_v  = ~dst_valid;
      end
      `OAF_M_DIR8L: begin
        addr_v = {16'h0, offs_reg[7:0]};
        sfr_v  = offs_reg[7];
      end
      `OAF_M_INDRI:
        addr_v = {`OAF_REGION_LOW, 8'h00, base_reg[7:0]};
      `OAF_M_DIR8X: begin
        addr_v = {15'h0, offs_reg[8:0]};
        sfr_v  = (offs_reg[8:0] >= 9'h080);
      end
      `OAF_M_DIRECT_ADDR_16:
        addr_v = {`OAF_REGION_LOW, offs_reg};
      `OAF_M_INDWR:
        addr_v = {`OAF_REGION_LOW, base_reg[15:0]};
      `OAF_M_INDDR: begin
        addr_v = base_reg[23:0];
        err_v  = (base_reg[31:24] != 8'h00);
      end
      `OAF_M_DISP16:
        addr_v = {`OAF_REGION_LOW, base_reg[15:0] + offs_reg};
      `OAF_M_DISP24: begin
        addr_v = base_reg[23:0] + offs_sx;
        err_v  = (base_reg[31:24] != 8'h00);
      end
      `OAF_M_REL:
        addr_v = next_pc_reg + offs_sx;
      `OAF_M_XDPTR:
        addr_v = {ext_pointer_region_byte_reg, data_pointer_16_reg};
      `OAF_M_XRI:
        addr_v = {ext_pointer_region_byte_reg, 8'h00, base_reg[7:0]};
      `OAF_M_CDPTR:
        addr_v = {`OAF_REGION_CODE, data_pointer_16_reg + acc_zx};
      `OAF_M_CPC:
        addr_v = {`OAF_REGION_CODE, next_pc_reg[15:0] + acc_zx};
      default: err_v = 1'b1;
    endcase
    // register space is a separate space reached one byte at a time
    if (sfr_v && (size != 2'd0))
      err_v = 1'b1;
  end
  wire [31:0] addr_result = {5'h00, file_v, err_v, sfr_v, addr_v};
  wire [31:0] reg_result  = {12'h000, src_mem, dst_mem, src_valid, dst_valid,
                             src_msb, dst_msb};
  // ------------------------------------------------------------
  // immediate former
  // ------------------------------------------------------------
  reg [31:0] imm_v;
  always @* begin
    case (ctrl_reg[22:21])
      2'd0:    imm_v = {16'h0000, offs_reg};
      2'd1:    imm_v = {16'hffff, offs_reg};
      2'd2:    imm_v = {{16{offs_reg[15]}}, offs_reg};
      default: imm_v = {offs_reg, base_reg[15:0]};
    endcase
  end
  // ------------------------------------------------------------
  // flag unit
  // ------------------------------------------------------------
  wire [31:0] fu_result;
  wire        fu_cy;
  wire        fu_ac;
  wire        fu_ov;
  wire        fu_n;
  wire        fu_z;
  wire        fu_store;
  oaf_flag_unit u_flag (
    .op     (wd_alu[3:0]),
    .width  (wd_alu[5:4]),
    .opa    (opa_reg),
    .opb    (opb_reg),
    .cy_in  (carry_flag_reg),
    .ac_in  (aux_carry_flag_reg),
    .ov_in  (overflow_flag_reg),
    .n_in   (neg_flag_reg),
    .z_in   (zero_flag_reg),
    .result (fu_result),
    .cy_out (fu_cy),
    .ac_out (fu_ac),
    .ov_out (fu_ov),
    .n_out  (fu_n),
    .z_out  (fu_z),
    .store  (fu_store)
  );
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  reg [31:0] rd_v;
  always @* begin
    case (avs_address)
      `OAF_A_PSW:    rd_v = {24'h0, primary_status_word};
      `OAF_A_SECOND_STATUS_WORD:   rd_v = {24'h0, second_status_word};
      `OAF_A_ACC:    rd_v = {24'h0, acc_reg};
      `OAF_A_REGION: rd_v = {24'h0, ext_pointer_region_byte_reg};
      `OAF_A_EDP:    rd_v = {8'h00, ext_pointer_region_byte_reg, data_pointer_16_reg};
      `OAF_A_BASE:   rd_v = base_reg;
      `OAF_A_OFFS:   rd_v = {16'h0, offs_reg};
      `OAF_A_PC:     rd_v = {8'h00, next_pc_reg};
      `OAF_A_CTRL:   rd_v = {9'h000, ctrl_reg};
      `OAF_A_ARES:   rd_v = addr_result;
      `OAF_A_RDEC:   rd_v = reg_result;
      `OAF_A_IMM:    rd_v = imm_v;
      `OAF_A_OPA:    rd_v = opa_reg;
      `OAF_A_OPB:    rd_v = opb_reg;
      `OAF_A_ALUCTL: rd_v = {26'h0, alu_ctl_reg};
      `OAF_A_ALURES: rd_v = alu_res_reg;
      default:       rd_v = 32'h0;
    endcase
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  wire wr_low = wr_take & avs_byteenable[0];
  always @(posedge clk) begin
    if (sys_rst) begin
      busy_reg                    <= 1'b0;
      avs_readdata                <= `OAF_RST_WORD;
      carry_flag_reg              <= `OAF_RST_FLAG;
      aux_carry_flag_reg          <= `OAF_RST_FLAG;
      overflow_flag_reg           <= `OAF_RST_FLAG;
      bank_select_lo_reg          <= `OAF_RST_FLAG;
      bank_select_hi_reg          <= `OAF_RST_FLAG;
      user_flag_a_reg             <= `OAF_RST_FLAG;
      user_flag_b_reg             <= `OAF_RST_FLAG;
      neg_flag_reg                <= `OAF_RST_FLAG;
      zero_flag_reg               <= `OAF_RST_FLAG;
      acc_reg                     <= 8'h00;
      ext_pointer_region_byte_reg <= `OAF_RST_REGION;
      data_pointer_16_reg         <= 16'h0000;
      base_reg                    <= `OAF_RST_WORD;
      offs_reg                    <= 16'h0000;
      next_pc_reg                 <= 24'h000000;
      ctrl_reg                    <= 23'h000000;
      opa_reg                     <= `OAF_RST_WORD;
      opb_reg                     <= `OAF_RST_WORD;
      alu_ctl_reg                 <= 6'h00;
      alu_res_reg                 <= `OAF_RST_WORD;
    end else begin
      busy_reg <= busy_next;
      if (avs_read & ~busy_reg)
        avs_readdata <= rd_v;
      if (wr_low && (avs_address == `OAF_A_PSW)) begin
        // parity is derived from the accumulator, so a write cannot touch it
        carry_flag_reg     <= avs_writedata[`OAF_B_CY];
        aux_carry_flag_reg <= avs_writedata[`OAF_B_AC];
        user_flag_a_reg    <= avs_writedata[`OAF_B_F0];
        bank_select_hi_reg <= avs_writedata[`OAF_B_RS1];
        bank_select_lo_reg <= avs_writedata[`OAF_B_RS0];
        overflow_flag_reg  <= avs_writedata[`OAF_B_OV];
        user_flag_b_reg    <= avs_writedata[`OAF_B_UD];
      end
      if (wr_low && (avs_address == `OAF_A_SECOND_STATUS_WORD)) begin
        carry_flag_reg     <= avs_writedata[`OAF_B_CY];
        aux_carry_flag_reg <= avs_writedata[`OAF_B_AC];
        neg_flag_reg       <= avs_writedata[`OAF_B_N];
        bank_select_hi_reg <= avs_writedata[`OAF_B_RS1];
        bank_select_lo_reg <= avs_writedata[`OAF_B_RS0];
        overflow_flag_reg  <= avs_writedata[`OAF_B_OV];
        zero_flag_reg      <= avs_writedata[`OAF_B_Z];
      end
      if (wr_low && (avs_address == `OAF_A_ACC))
        acc_reg <= avs_writedata[7:0];
      if (wr_low && (avs_address == `OAF_A_REGION))
        ext_pointer_region_byte_reg <= avs_writedata[7:0];
      if (wr_take && (avs_address == `OAF_A_EDP)) begin
        ext_pointer_region_byte_reg <= wd_edp[23:16];
        data_pointer_16_reg         <= wd_edp[15:0];
      end
      if (wr_take && (avs_address == `OAF_A_BASE))
        base_reg <= wd_base;
      if (wr_take && (avs_address == `OAF_A_OFFS))
        offs_reg <= wd_offs[15:0];
      if (wr_take && (avs_address == `OAF_A_PC))
        next_pc_reg <= wd_pc[23:0];
      if (wr_take && (avs_address == `OAF_A_CTRL))
        ctrl_reg <= wd_ctrl[22:0];
      if (wr_take && (avs_address == `OAF_A_OPA))
        opa_reg <= wd_opa;
      if (wr_take && (avs_address == `OAF_A_OPB))
        opb_reg <= wd_opb;
      // writing the operation word runs it on the held operands
      if (wr_take && (avs_address == `OAF_A_ALUCTL)) begin
        alu_ctl_reg        <= wd_alu[5:0];
        carry_flag_reg     <= fu_cy;
        aux_carry_flag_reg <= fu_ac;
        overflow_flag_reg  <= fu_ov;
        neg_flag_reg       <= fu_n;
        zero_flag_reg      <= fu_z;
        if (fu_store) begin
          alu_res_reg <= fu_result;
          if (wd_alu[5:4] == 2'd0)
            acc_reg <= fu_result[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/oaf_asserts.sv
// bus timing and read-value checks of the operand/flag block
`timescale 1ns/10ps
`default_nettype none
module oaf_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] acc_reg;
  logic       known_reg;
  wire        wr_done = avs_write && !avs_waitrequest;
  wire        rd_done = avs_read && !avs_waitrequest;
  // ----------
  // accumulator shadow, lost once an operation may load it
  // ----------
  always @(posedge clk) begin
    if (sys_rst) begin
      acc_reg <= 8'h00;
      known_reg <= 1'b1;
    end else if (wr_done && avs_address == 8'h08 && avs_byteenable[0]) begin
      acc_reg <= avs_writedata[7:0];
    end else if (wr_done && avs_address == 8'h38) begin
      known_reg <= 1'b0;
    end
  end
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_one_wait: assert property (s_req |-> s_one_wait) else $error("wait cycle count");
  a_idle_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  a_rd_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  a_par_bit: assert property (rd_done && avs_address == 8'h00 && known_reg |->
    avs_readdata[0] == ^acc_reg) else $error("parity bit wrong");
  a_second_status_word_low: assert property (rd_done && avs_address == 8'h04 |-> !avs_readdata[0])
    else $error("second status bit0 set");
  a_byte_regs: assert property (rd_done && avs_address < 8'h10 |->
    avs_readdata[31:8] == 24'h000000) else $error("byte register upper bits");
  a_edp_top: assert property (rd_done && avs_address == 8'h10 |->
    avs_readdata[31:24] == 8'h00) else $error("pointer top byte");
  a_unmapped_read: assert property (rd_done && avs_address >= 8'h40 |-> avs_readdata == 32'h0)
    else $error("unmapped read");
endmodule
bind oaf_top oaf_asserts oaf_asserts_i (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// file: tb/operand_addressing_and_flags_bench.sv
// self-checking bench of the operand/flag block
`timescale 1ns/10ps
`default_nettype none
module operand_addressing_and_flags_bench;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] m;
    logic [31:0] e;
  } oaf_row;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  logic [31:0] q;
  int          err_count = 0;
  int          n_tests = 0;
  // ----------
  // write one register, read one back under mask
  // ----------
  oaf_row rows [33] = '{
    '{8'h08,32'h3,8'h00,32'hff,32'h0}, '{8'h08,32'h7,8'h00,32'hff,32'h1},
    '{8'h00,32'hfe,8'h00,32'hff,32'hff}, '{8'h04,32'h0,8'h00,32'hff,32'h23},
    '{8'h14,32'hf000,8'h14,32'hffffffff,32'hf000}, '{8'h18,32'h2005,8'h18,32'hffff,32'h2005},
    '{8'h20,32'h7,8'h24,32'h3ffffff,32'h1005}, '{8'h1c,32'h1000,8'h1c,32'hffffff,32'h1000},
    '{8'h20,32'h9,8'h24,32'h3ffffff,32'h3005}, '{8'h18,32'h8000,8'h24,32'h3ffffff,32'hff9000},
    '{8'h10,32'h20100,8'h10,32'hffffffff,32'h20100},
    '{8'h20,32'hc,8'h24,32'h3ffffff,32'hff0107}, '{8'h20,32'ha,8'h24,32'h3ffffff,32'h20100},
    '{8'h30,32'hff,8'h30,32'hff,32'hff}, '{8'h34,32'h1,8'h34,32'hff,32'h1},
    '{8'h38,32'h0,8'h3c,32'hff,32'h0}, '{8'h40,32'hffffffff,8'h00,32'hff,32'he2},
    '{8'h40,32'h0,8'h04,32'hff,32'hc2}, '{8'h38,32'h4,8'h3c,32'hff,32'h0},
    '{8'h38,32'h10,8'h04,32'h40,32'h0}, '{8'h34,32'h0,8'h34,32'hff,32'h0},
    '{8'h38,32'h8,8'h04,32'h84,32'h4}, '{8'h34,32'h2,8'h34,32'hff,32'h2},
    '{8'h38,32'h7,8'h3c,32'hffff,32'h1fe}, '{8'h30,32'h81,8'h04,32'h84,32'h4},
    '{8'h38,32'ha,8'h04,32'ha0,32'h80}, '{8'h30,32'h80,8'h30,32'hff,32'h80},
    '{8'h38,32'hb,8'h3c,32'hff,32'hc0}, '{8'h40,32'h0,8'h04,32'h80,32'h0},
    '{8'h30,32'h10,8'h30,32'hff,32'h10}, '{8'h38,32'h5,8'h3c,32'hff,32'h14},
    '{8'h34,32'h1,8'h34,32'hff,32'h1}, '{8'h38,32'h6,8'h3c,32'hff,32'he}};
  oaf_top oaf_top_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  always #10 clk = ~clk;
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  // request stands until an edge samples waitrequest low; data taken at that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      bus(1'b0, rows[i].ra, 32'h0);
      chk($sformatf("row %0d", i), q & rows[i].m, rows[i].e);
      $display("test %0d done", i);
    end
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h0c, 32'h0);
    chk("region", q, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk("status", q, 32'h0);
    $display("reset test done");
    test_done;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire
